// *** hdl/int_sequencer.sv ***
`include "int_seq_regs.svh"
// *****************************************************
// Interrupt entry, vector fetch and return sequencer
// *****************************************************
module int_sequencer
   import int_seq_pkg::*;
#(
   parameter int SRC_N = `ISEQ_SRC_COUNT
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic rst_req, // Internal reset source, same clock
   input wire logic insn_done, // Instruction boundary pulse
   input wire logic insn_swi, // Finished instruction was the trap
   input wire logic swi_fetch, // Trap opcode fetched
   input wire logic rti_req, // Return instruction decoded
   input wire logic mask_set,
   input wire logic mask_clr,
   input wire cpu_regs_t cpu_state, // Live registers, pc = return
   input wire logic irq_pin_n, // External pin, asynchronous
   input wire logic [SRC_N-1:1] hw_req, // Peripheral flags
   input wire logic [SRC_N-1:0] src_enable, // Bit 0 is the pin
   input wire logic [7:0] stk_rdata, // Valid cycle after a pop
   input wire logic [7:0] mem_rdata, // Valid cycle after a read
   output logic stk_push_r,
   output logic stk_pop_r,
   output logic [7:0] stk_wdata_r,
   output logic vec_re_r,
   output logic [15:0] vec_addr_r,
   output logic pc_load_r,
   output logic [15:0] pc_value_r,
   output logic restore_r,
   output cpu_regs_t restore_val_r,
   output logic mask_r,
   output logic [SRC_N-1:0] src_ack_r,
   output logic busy_r
);
   // *****************************************************
   // Declarations
   // *****************************************************
   seq_state_t state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt; // Frame byte counter
   cpu_regs_t saved_r; // Frame captured at the boundary
   cpu_regs_t frame; // Frame source for the next push
   logic [SRC_N-1:0] raw, live; // Requests, with local enables
   logic [SRC_N-1:0] snap_r; // Requests older than the trap
   logic [SRC_N-1:0] scope_r; // Requests eligible at the check
   logic [SRC_N-1:0] take_req_r; // Requests at the boundary
   logic [SRC_N-1:0] cand, pick_set;
   logic [SRC_N-1:0] ack_nxt;
   logic swi_r; // Current entry came from the trap
   logic pin_req;
   logic hw_take, swi_take, entry;
   logic [15:0] vbase_r, vbase_nxt, vbase_sel;
   logic [7:0] vhi_r; // Fetched high vector byte
   logic [31:0] pop_sh_r; // CONDITION_CODE_REGISTER, A, X, PCH as they come back
   logic pop_d_r; // Pop data arrives this cycle
   logic [7:0] push_byte;
   logic mask_nxt;
   logic [$clog2(SRC_N)-1:0] sel_idx;

   // Highest vector address is the lowest index
   function automatic logic [$clog2(SRC_N)-1:0] pick(
      input logic [SRC_N-1:0] req);
      logic [$clog2(SRC_N)-1:0] w;
      w = '0;
      for (int i = SRC_N - 1; i >= 0; i--)
         if (req[i])
            w = i[$clog2(SRC_N)-1:0];
      return w;
   endfunction : pick

   // *****************************************************
   // Request gating
   // *****************************************************
   pin_event_latch u_pin (
      .clock(clock),
      .arst_n(arst_n),
      .pin_n(irq_pin_n),
      .pin_event_allow(src_enable[0]),
      .clear(src_ack_r[0]),
      .req(pin_req)
   );

   assign raw = {hw_req, pin_req};

   // Each source passes only with its own enable
   genvar g;
   generate
      for (g = 0; g < SRC_N; g++)
      begin : gate_g
         assign live[g] = raw[g] && src_enable[g]; // see R03
      end
   endgenerate

   // Hardware entry needs the mask clear; the trap ignores it
   assign hw_take = insn_done && !insn_swi && !mask_r
      && (|live); // see R03, R13
   assign swi_take = insn_done && insn_swi; // see R08
   assign entry = (state_r == ST_IDLE) && !rst_req
      && (hw_take || swi_take); // see R02

   // Candidates are judged after stacking; trap keeps older only
   assign cand = live & scope_r; // see R04, R09
   assign pick_set = (|cand) ? cand : (swi_r ? '0 : take_req_r);
   assign sel_idx = pick(pick_set); // see R10
   assign vbase_sel = (|pick_set)
      ? `ISEQ_VEC_PIN - `ISEQ_VEC_STEP * 16'(sel_idx) // see R10
      : `ISEQ_VEC_SWI; // see R08
   assign vbase_nxt = (state_r == ST_CHECK) ? vbase_sel
      : (state_r == ST_RSTV) ? `ISEQ_VEC_RST : vbase_r; // see R06
   assign ack_nxt = ((state_r == ST_CHECK) && (|pick_set))
      ? (SRC_N'(1) << sel_idx) : '0;

   // *****************************************************
   // Stack frame selection
   // *****************************************************
   // The boundary cycle pushes before saved_r is loaded
   assign frame = (state_r == ST_IDLE) ? cpu_state : saved_r;
   assign push_byte = (cnt_nxt == `ISEQ_FRAME_PCL) ? frame.pc[7:0]
      : (cnt_nxt == `ISEQ_FRAME_PCH) ? frame.pc[15:8]
      : (cnt_nxt == `ISEQ_FRAME_X) ? frame.idx
      : (cnt_nxt == `ISEQ_FRAME_A) ? frame.acc
      : {frame.condition_code_register[7:`ISEQ_CCR_I+1], mask_r,
         frame.condition_code_register[`ISEQ_CCR_I-1:0]}; // see R15

   assign cnt_nxt = ((state_nxt == ST_PUSH) || (state_nxt == ST_POP))
      && (state_r == state_nxt) ? cnt_r + `ISEQ_CNT_ONE : '0;

   // Reset outranks everything, even mid-sequence
   assign mask_nxt = rst_req ? 1'b1 // see R07
      : (state_r == ST_SEI) ? 1'b1 // see R01
      : (state_r == ST_RESUME) ? pop_sh_r[24+`ISEQ_CCR_I] // see R12
      : mask_set ? 1'b1 : mask_clr ? 1'b0 : mask_r;

   // *****************************************************
   // State machine
   // *****************************************************
   // Next state; stacking takes five cycles, each other entry step one
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (entry)
               state_nxt = ST_PUSH; // see R01
            else if (rti_req)
               state_nxt = ST_POP; // see R12
         ST_PUSH:
            if (cnt_r == `ISEQ_FRAME_LAST)
               state_nxt = ST_SEI;
         ST_SEI:
            state_nxt = ST_CHECK; // see R01
         ST_CHECK:
            state_nxt = ST_VHI;
         ST_RSTV:
            state_nxt = ST_VHI; // see R06
         ST_VHI:
            state_nxt = ST_VLO;
         ST_VLO:
            state_nxt = ST_LOAD;
         ST_LOAD:
            state_nxt = ST_IDLE; // see R11
         ST_POP:
            if (cnt_r == `ISEQ_FRAME_LAST)
               state_nxt = ST_RESUME;
         ST_RESUME:
            state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
      if (rst_req)
         state_nxt = ST_RSTV; // see R02, R06
   end

   // State and counters; power-up starts with the reset vector
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_RSTV;
         cnt_r <= '0;
         mask_r <= 1'b1; // see R07
         busy_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         mask_r <= mask_nxt;
         busy_r <= (state_nxt != ST_IDLE);
      end
   end

   // Entry context captured at the boundary and the trap fetch
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         saved_r <= '0;
         swi_r <= 1'b0;
         scope_r <= '0;
         take_req_r <= '0;
         snap_r <= '0;
      end
      else
      begin
         if (swi_fetch)
            snap_r <= live; // see R09
         if (entry)
         begin
            saved_r <= cpu_state;
            swi_r <= swi_take;
            take_req_r <= live;
            scope_r <= swi_take ? (mask_r ? '0 : snap_r) : '1;
         end
      end
   end

   // *****************************************************
   // Stack and vector ports
   // *****************************************************
   // Strobes track the next state so they line up with it
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stk_push_r <= 1'b0;
         stk_pop_r <= 1'b0;
         stk_wdata_r <= '0;
         vec_re_r <= 1'b0;
         vec_addr_r <= '0;
         vbase_r <= '0;
         src_ack_r <= '0;
      end
      else
      begin
         stk_push_r <= (state_nxt == ST_PUSH); // see R01
         stk_pop_r <= (state_nxt == ST_POP); // see R12
         stk_wdata_r <= push_byte; // see R15
         vec_re_r <= (state_nxt == ST_VHI) || (state_nxt == ST_VLO);
         vec_addr_r <= (state_nxt == ST_VLO)
            ? vbase_r + `ISEQ_VEC_NEXT : vbase_nxt; // see R05
         vbase_r <= vbase_nxt;
         src_ack_r <= ack_nxt;
      end
   end

   // Vector bytes and popped bytes come back a cycle later
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vhi_r <= '0;
         pc_load_r <= 1'b0;
         pc_value_r <= '0;
         pop_d_r <= 1'b0;
         pop_sh_r <= '0;
         restore_r <= 1'b0;
         restore_val_r <= '0;
      end
      else
      begin
         if (state_r == ST_VLO)
            vhi_r <= mem_rdata;
         pc_load_r <= (state_r == ST_LOAD) && !rst_req; // see R05
         if (state_r == ST_LOAD)
            pc_value_r <= {vhi_r, mem_rdata}; // see R05
         pop_d_r <= stk_pop_r;
         if (pop_d_r)
            pop_sh_r <= {pop_sh_r[23:0], stk_rdata}; // see R15
         restore_r <= (state_r == ST_RESUME) && !rst_req; // see R12
         if (state_r == ST_RESUME)
            restore_val_r <= {pop_sh_r[7:0], stk_rdata,
               pop_sh_r[23:16], pop_sh_r[15:8], pop_sh_r[31:24]};
      end
   end

   // *****************************************************
   // Assertions
   // *****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // Reset seen since the last entry; excuses a missing load pulse
   logic rst_hit_r;

   // Helper flag, cleared by each entry, set by an internal reset
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         rst_hit_r <= 1'b0;
      else if (entry)
         rst_hit_r <= 1'b0;
      else if (rst_req)
         rst_hit_r <= 1'b1;
   end

   push_frame_a: assert property ( // see R01, R15
      disable iff (!arst_n || rst_req)
      entry |=> stk_push_r [*5] ##1 !stk_push_r ##1 mask_r)
      else $error("stacking not five pushes then mask");
   no_abort_a: assert property ( // see R02
      (state_r == ST_IDLE && !insn_done && !rti_req) |=> !stk_push_r)
      else $error("stacking began mid instruction");
   masked_hold_a: assert property ( // see R03, R13
      (state_r == ST_IDLE && insn_done && !insn_swi && mask_r
       && !rti_req && !rst_req) |=> state_r == ST_IDLE)
      else $error("masked request was taken");
   entry_latency_a: assert property ( // see R11
      entry |-> ##11 (pc_load_r || rst_hit_r))
      else $error("handler not reached in ten cycles");
   reset_vec_a: assert property ( // see R06, R07
      rst_req && !$past(rst_req) |=> ##1 vec_re_r
      && vec_addr_r == `ISEQ_VEC_RST && mask_r)
      else $error("reset vector not fetched");
   swi_vec_a: assert property ( // see R08
      (entry && insn_swi && mask_r) ##1 !rst_req [*7]
      |=> vec_addr_r == `ISEQ_VEC_SWI && vec_re_r)
      else $error("trap vector wrong");
   prio_pick_a: assert property ( // see R04, R10
      (state_r == ST_CHECK && cand[0] && !rst_req) |=> src_ack_r[0]
      && vec_addr_r == `ISEQ_VEC_PIN)
      else $error("pin lost priority");
   pc_value_a: assert property ( // see R05
      pc_load_r |-> pc_value_r == {vhi_r, $past(mem_rdata)})
      else $error("handler address not from vector bytes");
   rti_restore_a: assert property ( // see R12
      (state_r == ST_IDLE && rti_req && !insn_done && !rst_req)
      ##1 !rst_req [*6] |=> restore_r)
      else $error("return did not restore");
   swi_order_a: assert property ( // see R09
      (state_r == ST_CHECK && swi_r && !(|cand) && !rst_req)
      |=> vec_addr_r == `ISEQ_VEC_SWI)
      else $error("trap vector not used");

   hw_entry_c: cover property (entry && hw_take);
   swi_entry_c: cover property (entry && swi_take);
   rti_c: cover property (restore_r);
   rst_mid_c: cover property (rst_req && busy_r);
endmodule : int_sequencer

// *** inc/int_seq_regs.svh ***
`ifndef INT_SEQ_REGS_SVH
`define INT_SEQ_REGS_SVH
// Function
// R01: Finish instruction, stack, set mask, then check
// R02: Requests wait for instruction end; reset aborts
// R03: Service needs mask clear and local enable
// R04: Highest vector address wins after stacking
// R05: Handler address is two vector bytes
// R06: Reset fetches start address from top pair
// R07: Every reset sets the global mask bit
// R08: Software trap ignores mask, uses next pair
// R09: Trap follows older requests, precedes newer
// R10: Fixed source order, port C lowest
// R11: Entry overhead at most ten cycles
// R12: Return pops state and resumes execution
// R13: Mask bit blocks all hardware requests
// R14: Pin edge latched while its enable off
// R15: Push PCL, PCH, X, A, CONDITION_CODE_REGISTER; pop reversed

// *****************************************************
// Vector table
// *****************************************************
`define ISEQ_VEC_RST 16'h3FFE
`define ISEQ_VEC_SWI 16'h3FFC
`define ISEQ_VEC_PIN 16'h3FFA
`define ISEQ_VEC_STEP 16'h0002
`define ISEQ_VEC_NEXT 16'h0001

// *****************************************************
// Condition codes and stack frame
// *****************************************************
`define ISEQ_CCR_I 3
`define ISEQ_FRAME_PCL 3'h0
`define ISEQ_FRAME_PCH 3'h1
`define ISEQ_FRAME_X 3'h2
`define ISEQ_FRAME_A 3'h3
`define ISEQ_FRAME_LAST 3'h4
`define ISEQ_CNT_ONE 3'h1
`define ISEQ_SRC_COUNT 6
`endif

// *** inc/int_seq_pkg.sv ***
// *****************************************************
// Types shared by the sequencer files
// *****************************************************
package int_seq_pkg;
   // CPU register image that is stacked and restored
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] acc;
      logic [7:0] idx;
      logic [7:0] condition_code_register;
   } cpu_regs_t;

   // Sequencer states, Gray coded along the entry path
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PUSH = 4'h1,
      ST_SEI = 4'h3,
      ST_CHECK = 4'h2,
      ST_VHI = 4'h6,
      ST_VLO = 4'h7,
      ST_LOAD = 4'h5,
      ST_POP = 4'h4,
      ST_RESUME = 4'hC,
      ST_RSTV = 4'hD
   } seq_state_t;
endpackage : int_seq_pkg

// *** hdl/pin_event_latch.sv ***
`include "int_seq_regs.svh"
// *****************************************************
// External pin synchroniser and falling-edge latch
// *****************************************************
module pin_event_latch
   import int_seq_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic pin_n,
   input wire logic pin_event_allow,
   input wire logic clear,
   output logic req
);
   logic s1_r; // First stage, read only by s2_r
   logic s2_r;
   logic s3_r;
   logic lvl_r; // Agreed pin level
   logic edge_r; // Latched falling edge
   logic fall; // Agreed level goes high to low
   logic agree; // Second and third stage match

   assign agree = (s2_r == s3_r);
   assign fall = agree && !s2_r && lvl_r;

   // Three-stage synchroniser, pin idles high
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         lvl_r <= 1'b1;
      end
      else
      begin
         s1_r <= pin_n;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree)
            lvl_r <= s2_r;
      end
   end

   // Edge kept even while disabled; a new edge beats the clear
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         edge_r <= 1'b0;
      else if (fall) // see R14
         edge_r <= 1'b1;
      else if (clear)
         edge_r <= 1'b0;
   end

   // Low level is a live request, never latched
   assign req = pin_event_allow && (edge_r || !lvl_r); // see R14

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   edge_held_a: assert property ( // see R14
      (fall && !pin_event_allow) |=> edge_r [*2])
      else $error("pin edge not held while disabled");
   edge_release_a: assert property ( // see R14
      (edge_r && pin_event_allow) |-> req)
      else $error("held pin edge not requested once allowed");
endmodule : pin_event_latch

// *** dv/cpu_core_model.sv ***
// *****************************************************
// Core side: stack memory and vector table
// *****************************************************
module cpu_core_model
(
   input wire logic clock,
   input wire logic stk_push_r,
   input wire logic stk_pop_r,
   input wire logic [7:0] stk_wdata_r,
   input wire logic vec_re_r,
   input wire logic [15:0] vec_addr_r,
   output logic [7:0] stk_rdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] stack_mem [256]; // Stack bytes
   logic [7:0] sp_r = 8'h00; // Next free slot
   // *****************************************************
   // Answers land the cycle after each strobe
   // *****************************************************
   always @(posedge clock)
   begin
      // Idle lines toggle so a stale byte never looks valid
      stk_rdata <= ~stk_rdata;
      mem_rdata <= ~mem_rdata;
      if (stk_push_r) // Last in, first out
      begin
         stack_mem[sp_r] <= stk_wdata_r;
         sp_r <= sp_r + 8'h01;
      end
      if (stk_pop_r) // Reverse order on return
      begin
         stk_rdata <= stack_mem[sp_r - 8'h01];
         sp_r <= sp_r - 8'h01;
      end
      if (vec_re_r) // Table byte is the inverted address
      begin
         mem_rdata <= ~vec_addr_r[7:0];
      end
   end
   initial
   begin
      stk_rdata = 8'h00;
      mem_rdata = 8'h00;
   end
endmodule : cpu_core_model

// *** dv/test_int_sequencer.sv ***
// *****************************************************
// Self-checking bench for the interrupt sequencer
// *****************************************************
module test_int_sequencer
   import int_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [5:1] hw; // Peripheral requests
      logic [5:0] en; // Local enables
      logic msk; // Leave the mask set
      logic software_trap_instruction; // Boundary is the trap
      logic tk; // Entry expected
      logic [15:0] base; // Expected vector pair
   } row_t;
   // Ordinary cases: one source each, overlaps, blocked ones
   row_t rows [11] = '{
      {5'h01, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF8},
      {5'h02, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF6},
      {5'h04, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF4},
      {5'h08, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF2},
      {5'h10, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF0},
      {5'h1F, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF8},
      {5'h12, 6'h3F, 1'b0, 1'b0, 1'b1, 16'h3FF6},
      {5'h01, 6'h3F, 1'b1, 1'b0, 1'b0, 16'h0000},
      {5'h01, 6'h3D, 1'b0, 1'b0, 1'b0, 16'h0000},
      {5'h01, 6'h3F, 1'b1, 1'b1, 1'b1, 16'h3FFC},
      {5'h00, 6'h3F, 1'b0, 1'b1, 1'b1, 16'h3FFC}};
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic rst_req = 1'b0;
   logic insn_done = 1'b0;
   logic insn_swi = 1'b0;
   logic swi_fetch = 1'b0;
   logic rti_req = 1'b0;
   logic mask_set = 1'b0;
   logic mask_clr = 1'b0;
   cpu_regs_t cpu_state = '0;
   logic irq_pin_n = 1'b1; // Pin idles high
   logic [5:1] hw_req = 5'h00;
   logic [5:0] src_enable = 6'h00;
   logic [7:0] stk_rdata, mem_rdata, stk_wdata_r;
   logic stk_push_r, stk_pop_r, vec_re_r, pc_load_r, restore_r;
   logic mask_r, busy_r;
   logic [15:0] vec_addr_r, pc_value_r;
   logic [5:0] src_ack_r;
   cpu_regs_t restore_val_r, saved;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] n;
   logic ack_clr = 1'b0; // Empties the acknowledge log
   logic [5:0] ack_seen = 6'h00; // Acknowledges since the last clear
   logic [5:0] ack_exp; // Acknowledge a row should give
   always #20 clock = ~clock;
   // Sticky log of acknowledge pulses
   always @(posedge clock)
      ack_seen <= ack_clr ? 6'h00 : (ack_seen | src_ack_r);
   int_sequencer u_int_sequencer (.clock(clock), .arst_n(arst_n),
      .rst_req(rst_req), .insn_done(insn_done), .insn_swi(insn_swi),
      .swi_fetch(swi_fetch), .rti_req(rti_req), .mask_set(mask_set),
      .mask_clr(mask_clr), .cpu_state(cpu_state),
      .irq_pin_n(irq_pin_n), .hw_req(hw_req), .src_enable(src_enable),
      .stk_rdata(stk_rdata), .mem_rdata(mem_rdata),
      .stk_push_r(stk_push_r), .stk_pop_r(stk_pop_r),
      .stk_wdata_r(stk_wdata_r), .vec_re_r(vec_re_r),
      .vec_addr_r(vec_addr_r), .pc_load_r(pc_load_r),
      .pc_value_r(pc_value_r), .restore_r(restore_r),
      .restore_val_r(restore_val_r), .mask_r(mask_r),
      .src_ack_r(src_ack_r), .busy_r(busy_r));
   cpu_core_model u_cpu_core_model (.clock(clock),
      .stk_push_r(stk_push_r), .stk_pop_r(stk_pop_r),
      .stk_wdata_r(stk_wdata_r), .vec_re_r(vec_re_r),
      .vec_addr_r(vec_addr_r), .stk_rdata(stk_rdata),
      .mem_rdata(mem_rdata));
   // *****************************************************
   // Shared tasks
   // *****************************************************
   task check(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask : check
   task step; // Inputs move 1 ns after the edge
      @(posedge clock);
      #1;
   endtask : step
   task boundary(input logic software_trap_instruction);
      insn_done = 1'b1;
      insn_swi = software_trap_instruction;
      step;
      insn_done = 1'b0;
      insn_swi = 1'b0;
   endtask : boundary
   // Clears the mask (unless mask_set is up) and the acknowledge log
   task unmask;
      mask_clr = 1'b1;
      ack_clr = 1'b1;
      step;
      mask_clr = 1'b0;
      mask_set = 1'b0;
      ack_clr = 1'b0;
      step;
   endtask : unmask
   // Bounded wait on the load pulse (sel 0) or restore (sel 1)
   task wait_for(input logic sel);
      n = 8'h00;
      do
      begin
         step;
         n++;
      end
      while (((sel ? restore_r : pc_load_r) !== 1'b1) && n < 8'h14);
   endtask : wait_for
   function logic [15:0] pcx(input logic [15:0] b);
      return {~b[7:0], ~(b[7:0] + 8'h01)};
   endfunction : pcx
   task complete_run;
      $display("Compared %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // Hang guard, far above the expected run length
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         complete_run;
      end
   end
   // *****************************************************
   // Main sequence
   // *****************************************************
   initial
   begin
      repeat (5) @(posedge clock);
      #1 arst_n = 1'b1;
      wait_for(1'b0);
      check({mask_r, pc_value_r}, {1'b1, pcx(16'h3FFE)});
      $display("reset test done");
      foreach (rows[i])
      begin
         // Masked rows set the mask, the others clear it
         mask_set = rows[i].msk;
         unmask;
         hw_req = rows[i].hw;
         src_enable = rows[i].en;
         boundary(rows[i].software_trap_instruction);
         wait_for(1'b0);
         // Taken hardware rows acknowledge the source behind their vector
         ack_exp = (rows[i].tk && !rows[i].software_trap_instruction)
            ? 6'h01 << ((16'h3FFA - rows[i].base) >> 1) : 6'h00;
         // Load 10 steps after the boundary, nothing otherwise
         check({mask_r, busy_r, ack_seen, n,
            rows[i].tk ? pc_value_r : 16'h0000},
            {rows[i].tk | rows[i].msk, 1'b0, ack_exp,
            rows[i].tk ? 8'h0A : 8'h14,
            rows[i].tk ? pcx(rows[i].base) : 16'h0000});
         hw_req = 5'h00;
         step;
      end
      $display("row tests done");
      // Stack a known image, then return from the handler
      unmask;
      saved = {16'h1234, 8'h56, 8'h78, 8'h00};
      cpu_state = saved;
      hw_req = 5'h01;
      boundary(1'b0);
      wait_for(1'b0);
      hw_req = 5'h00;
      cpu_state = '0;
      rti_req = 1'b1;
      step;
      rti_req = 1'b0;
      wait_for(1'b1);
      check({n, restore_val_r}, {8'h06, saved});
      check(mask_r, 1'b0);
      $display("return test done");
      // Older request outranks a trap fetched after it
      unmask;
      hw_req = 5'h01;
      swi_fetch = 1'b1;
      step;
      swi_fetch = 1'b0;
      boundary(1'b1);
      wait_for(1'b0);
      hw_req = 5'h00;
      check({ack_seen, pc_value_r}, {6'h02, pcx(16'h3FF8)});
      $display("trap order test done");
      // Pin edge while disallowed stays pending
      unmask;
      src_enable = 6'h00;
      irq_pin_n = 1'b0;
      repeat (6) step;
      irq_pin_n = 1'b1;
      repeat (6) step;
      src_enable = 6'h01;
      boundary(1'b0);
      wait_for(1'b0);
      check({ack_seen, pc_value_r}, {6'h01, pcx(16'h3FFA)});
      $display("pin latch test done");
      // Internal reset aborts an entry in mid-stack
      unmask;
      boundary(1'b1);
      repeat (3) step;
      rst_req = 1'b1;
      step;
      rst_req = 1'b0;
      wait_for(1'b0);
      check({mask_r, pc_value_r}, {1'b1, pcx(16'h3FFE)});
      $display("abort test done");
      complete_run;
   end
endmodule : test_int_sequencer
